// [sd_port_pkg.sv]
// package: constants and carriers for the converter serial port
package sd_port_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned CMD_W  = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CNT_W  = 5;
  localparam int unsigned ONES_W = 6;

  // ----------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------
  localparam int unsigned READY_BIT = 7;
  localparam int unsigned SEL_HI    = 5;
  localparam int unsigned SEL_LO    = 4;
  localparam int unsigned RW_BIT    = 3;
  localparam int unsigned STBY_BIT  = 2;
  localparam int unsigned GAIN_HI   = 1;
  localparam int unsigned GAIN_LO   = 0;

  localparam logic [1:0] SEL_CMD   = 2'h0;
  localparam logic [1:0] SEL_SETUP = 2'h1;
  localparam logic [1:0] SEL_SPARE = 2'h2;
  localparam logic [1:0] SEL_DATA  = 2'h3;

  // ----------------------------------------------------------------
  // counts and reset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0]  LAST_BYTE = 5'h07;
  localparam logic [CNT_W-1:0]  LAST_WORD = 5'h0F;
  localparam logic [ONES_W-1:0] ONES_RUN  = 6'h20;
  localparam logic [CMD_W-1:0]  CMD_RST   = 8'h00;
  localparam logic [CMD_W-1:0]  SETUP_RST = 8'h00;
  localparam logic [WORD_W-1:0] DATA_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // states and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {M_CMD, M_WR, M_RD} link_mode_e;
  typedef enum logic [1:0] {P_IDLE, P_UPD, P_ANN} core_phase_e;

  typedef struct packed {
    link_mode_e         mode;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   last;
    logic [1:0]         target;
    logic [WORD_W-1:0]  rx;
    logic [WORD_W-1:0]  tx;
    logic [ONES_W-1:0]  ones;
    logic [CMD_W-1:0]   cmd;
    logic [CMD_W-1:0]   setup;
    logic               cfg_tgl;
    logic               rd_tgl;
  } link_s;

  typedef struct packed {
    core_phase_e        phase;
    logic [WORD_W-1:0]  pend;
    logic [WORD_W-1:0]  data;
    logic               ready_n;
    logic               rd_prev;
    logic               cfg_prev;
    logic [1:0]         gain;
    logic               stby;
    logic [CMD_W-1:0]   setup;
  } core_s;

  typedef struct packed {
    logic dout;
  } tx_s;

endpackage : sd_port_pkg

// [sd_sync2.sv]
// module: two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sd_sync2 (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // level in and out
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // first flop feeds only the second
  always_comb begin
    s_d        = s_q;
    s_d.meta   = d;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stable;

endmodule : sd_sync2
`default_nettype wire

// [sd_serial_port.sv]
// module: serial register port of a single-channel sigma-delta converter
//
// Contract
// - every register access starts with a command register write
// - three registers: command, setup and conversion data
// - command and setup are 8 bits, data is 16 bits
// - 16-bit data reads as one 16-bit or two 8-bit transfers
// - after eight command clocks the selected operation starts at once
// - in write operations the serial output is never driven
// - in read operations the serial input is ignored
// - data-ready shows on its pin and as command register top bit
// - data-ready falls on new word, rises on read and before update
// - 32 serial clocks of ones outside read operations return port to await a command
// - command value selects read or write and the target register
`timescale 1ns/1ps
`default_nettype none
module sd_serial_port
  import sd_port_pkg::*;
(
  // system clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // serial link from the host
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              din,
  output logic                   dout,
  output logic                   dout_oe,
  // conversion results
  input  wire logic              sample_valid,
  input  wire logic [WORD_W-1:0] sample_data,
  output logic                   data_ready_n,
  // configuration seen by the converter
  output logic [1:0]             cfg_gain,
  output logic                   cfg_standby,
  output logic [CMD_W-1:0]       cfg_setup
);

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  link_s l_q;
  link_s l_d;
  core_s c_q;
  core_s c_d;
  tx_s   t_q;
  tx_s   t_d;
  logic  oe_q;
  logic  ready_n_link;
  logic  rd_tgl_core;
  logic  cfg_tgl_core;
  logic  oe_rst_n;

  sd_sync2 u_ready_sync (
    .clk     (sclk),
    .reset_n (reset_n),
    .d       (c_q.ready_n),
    .q       (ready_n_link)
  );

  sd_sync2 u_rd_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (l_q.rd_tgl),
    .q       (rd_tgl_core)
  );

  sd_sync2 u_cfg_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (l_q.cfg_tgl),
    .q       (cfg_tgl_core)
  );

  // ----------------------------------------------------------------
  // link side, rising edge of the serial clock
  // ----------------------------------------------------------------
  // the data word is loaded straight from the core register: it only
  // changes while data-ready is high, so a host that waits is safe
  always_comb begin
    logic [WORD_W-1:0] word_in;
    logic [CMD_W-1:0]  rd_cmd;
    word_in = {l_q.rx[WORD_W-2:0], din};
    // a read of the command register returns the byte just written, with data-ready in its top bit
    rd_cmd  = word_in[CMD_W-1:0];
    rd_cmd[READY_BIT] = ready_n_link;
    l_d = l_q;
    if (!cs_n) begin
      l_d.cnt = l_q.cnt + 5'h01;
      if (l_q.mode != M_RD) begin
        l_d.rx = word_in;
        if (!din) begin
          l_d.ones = '0;
        end else if (l_q.ones != ONES_RUN) begin
          l_d.ones = l_q.ones + 6'h01;
        end
      end
      unique case (l_q.mode)
        M_CMD: begin
          if (l_q.cnt == LAST_BYTE) begin
            l_d.cnt    = '0;
            l_d.cmd    = word_in[CMD_W-1:0];
            l_d.target = word_in[SEL_HI:SEL_LO];
            l_d.last   = (word_in[SEL_HI:SEL_LO] == SEL_DATA) ?
                         LAST_WORD : LAST_BYTE;
            l_d.cfg_tgl = ~l_q.cfg_tgl;
            if (word_in[RW_BIT]) begin
              l_d.mode = M_RD;
              unique case (word_in[SEL_HI:SEL_LO])
                SEL_CMD:   l_d.tx = {rd_cmd, CMD_RST};
                SEL_SETUP: l_d.tx = {l_q.setup, CMD_RST};
                SEL_SPARE: l_d.tx = DATA_RST;
                SEL_DATA:  l_d.tx = c_q.data;
              endcase
            end else if (word_in[SEL_HI:SEL_LO] != SEL_CMD) begin
              l_d.mode = M_WR;
            end
          end
        end
        M_WR: begin
          if (l_q.cnt == l_q.last) begin
            l_d.cnt  = '0;
            l_d.mode = M_CMD;
            if (l_q.target == SEL_SETUP) begin
              l_d.setup   = word_in[CMD_W-1:0];
              l_d.cfg_tgl = ~l_q.cfg_tgl;
            end
          end
        end
        M_RD: begin
          // count runs across frames, so two bytes read as one word
          l_d.tx = {l_q.tx[WORD_W-2:0], 1'b0};
          if (l_q.cnt == l_q.last) begin
            l_d.cnt  = '0;
            l_d.mode = M_CMD;
            if (l_q.target == SEL_DATA) begin
              l_d.rd_tgl = ~l_q.rd_tgl;
            end
          end
        end
        default: begin
          l_d.mode = M_CMD;
          l_d.cnt  = '0;
        end
      endcase
      // a run of ones wins over any write in flight
      if (l_q.mode != M_RD && din && l_q.ones == ONES_RUN - 6'h01) begin
        l_d.mode = M_CMD;
        l_d.cnt  = '0;
        l_d.ones = '0;
        l_d.cfg_tgl = l_q.cfg_tgl;
        l_d.setup   = l_q.setup;
        l_d.cmd     = l_q.cmd;
      end
    end
  end

  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      l_q       <= '0;
      l_q.mode  <= M_CMD;
      l_q.last  <= LAST_BYTE;
      l_q.cmd   <= CMD_RST;
      l_q.setup <= SETUP_RST;
    end else begin
      l_q <= l_d;
    end
  end

  // ----------------------------------------------------------------
  // link side, falling edge: output bit and its enable
  // ----------------------------------------------------------------
  // enable drops at once when select rises, without waiting for a clock
  assign oe_rst_n = reset_n & ~cs_n;

  always_comb begin
    t_d      = t_q;
    t_d.dout = l_q.tx[WORD_W-1];
  end

  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  always_ff @(negedge sclk or negedge oe_rst_n) begin
    if (!oe_rst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= (l_q.mode == M_RD);
    end
  end

  // ----------------------------------------------------------------
  // core side: output register and data-ready
  // ----------------------------------------------------------------
  always_comb begin
    c_d          = c_q;
    c_d.rd_prev  = rd_tgl_core;
    c_d.cfg_prev = cfg_tgl_core;
    if (rd_tgl_core != c_q.rd_prev) begin
      c_d.ready_n = 1'b1;
    end
    if (cfg_tgl_core != c_q.cfg_prev) begin
      c_d.gain  = l_q.cmd[GAIN_HI:GAIN_LO];
      c_d.stby  = l_q.cmd[STBY_BIT];
      c_d.setup = l_q.setup;
    end
    unique case (c_q.phase)
      P_IDLE: begin
        if (sample_valid) begin
          c_d.pend    = sample_data;
          c_d.ready_n = 1'b1;
          c_d.phase   = P_UPD;
        end
      end
      P_UPD: begin
        c_d.data  = c_q.pend;
        c_d.phase = P_ANN;
      end
      P_ANN: begin
        // new word wins over a read finishing in the same cycle
        c_d.ready_n = 1'b0;
        c_d.phase   = P_IDLE;
      end
      default: begin
        c_d.phase = P_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      c_q         <= '0;
      c_q.phase   <= P_IDLE;
      c_q.data    <= DATA_RST;
      c_q.ready_n <= 1'b1;
      c_q.gain    <= CMD_RST[GAIN_HI:GAIN_LO];
      c_q.stby    <= CMD_RST[STBY_BIT];
      c_q.setup   <= SETUP_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dout         = t_q.dout;
  assign dout_oe      = oe_q;
  assign data_ready_n = c_q.ready_n;
  assign cfg_gain     = c_q.gain;
  assign cfg_standby  = c_q.stby;
  assign cfg_setup    = c_q.setup;

endmodule : sd_serial_port
`default_nettype wire

// [sd_port_sva.sv]
// checker: timing relations at the serial port pins
`timescale 1ns/1ps
`default_nettype none
module sd_port_sva
  import sd_port_pkg::*;
(
  // clocks and reset
  input wire logic             clk,
  input wire logic             reset_n,
  input wire logic             sclk,
  // watched pins
  input wire logic             cs_n,
  input wire logic             dout_oe,
  input wire logic             sample_valid,
  input wire logic             data_ready_n,
  input wire logic [1:0]       cfg_gain,
  input wire logic             cfg_standby,
  input wire logic [CMD_W-1:0] cfg_setup
);
  // ----------------------------------------------------------------
  // clk cycles since select went high, saturating
  // ----------------------------------------------------------------
  logic [3:0] quiet_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) quiet_q <= 4'h0;
    else if (!cs_n) quiet_q <= 4'h0;
    else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
  end

  property p_new_word;
    @(posedge clk) disable iff (!reset_n)
    sample_valid |=> data_ready_n ##2 !data_ready_n;
  endproperty
  a_new_word: assert property (p_new_word)
    else $error("ready did not announce new word");
  property p_fall_cause;
    @(posedge clk) disable iff (!reset_n)
    $fell(data_ready_n) |-> $past(sample_valid, 3);
  endproperty
  a_fall_cause: assert property (p_fall_cause)
    else $error("ready fell without a new word");
  property p_oe_sel;
    @(posedge clk) disable iff (!reset_n) dout_oe |-> !cs_n;
  endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("output driven while deselected");
  // cfg may only move during or shortly after a serial frame
  property p_cfg_cause;
    @(posedge clk) disable iff (!reset_n)
    $changed({cfg_gain, cfg_standby, cfg_setup}) |-> quiet_q < 4'h8;
  endproperty
  a_cfg_cause: assert property (p_cfg_cause)
    else $error("configuration changed with no access");
  property p_rdy_hold;
    @(posedge clk) disable iff (!reset_n)
    !data_ready_n && !sample_valid && quiet_q > 4'h6 |=> !data_ready_n;
  endproperty
  a_rdy_hold: assert property (p_rdy_hold)
    else $error("ready released with no read");
  property p_rdy_rise;
    @(posedge clk) disable iff (!reset_n)
    $rose(data_ready_n) |-> $past(sample_valid) || quiet_q < 4'h7;
  endproperty
  a_rdy_rise: assert property (p_rdy_rise)
    else $error("ready rose with no cause");
  property p_oe_len;
    @(negedge sclk) disable iff (!reset_n) $rose(dout_oe) |-> dout_oe[*7];
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("read shorter than a byte");
  property p_oe_after_cmd;
    @(negedge sclk) disable iff (!reset_n)
    $rose(dout_oe) |-> !$past(dout_oe, 8) || $past(dout_oe, 2);
  endproperty
  a_oe_after_cmd: assert property (p_oe_after_cmd)
    else $error("read began without a command byte");
endmodule : sd_port_sva
bind sd_serial_port sd_port_sva u_sva (.clk(clk), .reset_n(reset_n),
  .sclk(sclk), .cs_n(cs_n), .dout_oe(dout_oe),
  .sample_valid(sample_valid), .data_ready_n(data_ready_n),
  .cfg_gain(cfg_gain), .cfg_standby(cfg_standby), .cfg_setup(cfg_setup));
`default_nettype wire

// [sd_host.sv]
// partner: host serial master, clock idles high, msb first
`timescale 1ns/1ps
`default_nettype none
module sd_host (
  // serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout,
  input  wire logic dout_oe
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // undriven output bits come back as x so a stray drive shows
  task automatic xfer(input logic [23:0] tx, input int n,
                      output logic [23:0] rx);
    rx = 'x;
    #7 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      // 48 ns serial period, well inside the framed-host limit
      #24 sclk = 1'b0;
      din = tx[i];
      #24 sclk = 1'b1;
      rx = {rx[22:0], dout_oe ? dout : 1'bx};
    end
    #24 cs_n = 1'b1;
    din = ~din;
  endtask : xfer
endmodule : sd_host
`default_nettype wire

// [testbench.sv]
// testbench: register traffic through the serial port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sd_port_pkg::*;
  logic              clk, reset_n, sclk, cs_n, din, dout, dout_oe;
  logic              sample_valid, data_ready_n, cfg_standby;
  logic [WORD_W-1:0] sample_data;
  logic [1:0]        cfg_gain;
  logic [CMD_W-1:0]  cfg_setup;
  logic [23:0]       rx;
  int                errors, checks_done;

  sd_serial_port dut (.clk(clk), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .data_ready_n(data_ready_n), .cfg_gain(cfg_gain),
    .cfg_standby(cfg_standby), .cfg_setup(cfg_setup));
  sd_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe));

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [23:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // the wait lets crossings into the clk domain settle
  task automatic xf(input logic [23:0] tx, input int n);
    host.xfer(tx, n, rx);
    cyc(8);
  endtask : xf
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    sample_valid = 1'b0;
    sample_data = 16'h0000;
    errors = 0;
    checks_done = 0;
    cyc(10);
    reset_n = 1'b1;
    cyc(2);
    chk("reset", {data_ready_n, dout_oe, cfg_gain, cfg_standby,
        cfg_setup}, {1'b1, 12'h000});
    $display("test reset done");
    xf({8'h10, 8'hA5}, 16);
    chk("write_quiet", rx[15:0], 16'hxxxx);
    xf(8'h07, 8);
    chk("cfg", {cfg_gain, cfg_standby, cfg_setup}, 11'h7A5);
    xf({8'h18, 8'hFF}, 16);
    chk("setup_read", rx[7:0], 8'hA5);
    $display("test setup done");
    sample_data = 16'hC3A9;
    sample_valid = 1'b1;
    cyc(1);
    sample_valid = 1'b0;
    cyc(4);
    chk("ready_low", data_ready_n, 1'b0);
    xf({8'h08, 8'h00}, 16);
    chk("cmd_read", rx[7:0], 8'h08);
    xf(8'h38, 8);
    xf(8'hFF, 8);
    chk("data_hi", rx[7:0], 8'hC3);
    xf(8'hFF, 8);
    chk("data_lo", rx[7:0], 8'hA9);
    chk("ready_high", data_ready_n, 1'b1);
    xf({8'h08, 8'h00}, 16);
    chk("cmd_read2", rx[7:0], 8'h88);
    xf({8'h30, 16'h1234}, 24);
    xf({8'h38, 16'h0000}, 24);
    chk("data_word", rx[15:0], 16'hC3A9);
    $display("test data done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
